// >>> shared/tpg_pkg.sv
// Purpose: Constants and carrier types of the link test pattern generator
// Assumes: Byte-wide configuration registers at their printed addresses
// Notes:   Two converters by two samples per frame on the sample path
package tpg_pkg;

	// ****************************************************************
	// Register addresses, reset values and field positions
	// ****************************************************************
	localparam logic [15:0] TPG_ADDR_SOFT_RESET = 16'h0000;
	localparam logic [15:0] TPG_ADDR_SYNC_CTRL = 16'h0572;
	localparam logic [15:0] TPG_ADDR_TEST_CTRL = 16'h0573;
	localparam logic [15:0] TPG_ADDR_USER_FIRST = 16'h0551;
	localparam logic [15:0] TPG_ADDR_USER_LAST = 16'h0558;
	localparam logic [7:0] TPG_SOFT_RESET_CODE = 8'h81;
	localparam logic [7:0] TPG_TEST_CTRL_RESET = 8'h00;
	localparam logic [7:0] TPG_SYNC_CTRL_RESET = 8'h00;
	localparam logic [7:0] TPG_USER_RESET = 8'h00;
	localparam logic [7:0] TPG_SYNC_DISABLE_CODE = 8'hc0;
	localparam logic [7:0] TPG_TEST_CTRL_WMASK = 8'h3f;
	localparam int TPG_MODE_LSB = 0;
	localparam int TPG_POINT_LSB = 4;
	localparam int TPG_DONE_BIT = 7;

	// ****************************************************************
	// Test mode codes and injection points
	// ****************************************************************
	localparam logic [3:0] TPG_MODE_OFF = 4'h0;
	localparam logic [3:0] TPG_MODE_CHECKER = 4'h1;
	localparam logic [3:0] TPG_MODE_TOGGLE = 4'h2;
	localparam logic [3:0] TPG_MODE_PN31 = 4'h3;
	localparam logic [3:0] TPG_MODE_PN23 = 4'h4;
	localparam logic [3:0] TPG_MODE_PN15 = 4'h5;
	localparam logic [3:0] TPG_MODE_PN9 = 4'h6;
	localparam logic [3:0] TPG_MODE_PN7 = 4'h7;
	localparam logic [3:0] TPG_MODE_RAMP = 4'h8;
	localparam logic [3:0] TPG_MODE_USER_REPEAT = 4'he;
	localparam logic [3:0] TPG_MODE_USER_SINGLE = 4'hf;
	localparam logic [1:0] TPG_POINT_SAMPLE = 2'b00;
	localparam logic [1:0] TPG_POINT_PHY = 2'b01;
	localparam logic [1:0] TPG_POINT_SCRAMBLER = 2'b10;

	// ****************************************************************
	// Word widths, pattern words and generator seeds
	// ****************************************************************
	localparam logic [4:0] TPG_SAMPLE_W = 5'h10;
	localparam logic [4:0] TPG_PHY_W = 5'h0a;
	localparam logic [4:0] TPG_OCTET_W = 5'h08;
	localparam int TPG_NUM_SAMPLES = 4;
	localparam int TPG_FIFO_DEPTH = 4;
	localparam logic [15:0] TPG_CHECKER_EVEN = 16'h5555;
	localparam logic [15:0] TPG_CHECKER_ODD = 16'haaaa;
	localparam logic [15:0] TPG_TOGGLE_EVEN = 16'h0000;
	localparam logic [15:0] TPG_TOGGLE_ODD = 16'hffff;
	localparam logic [30:0] TPG_SEED_PN31 = 31'h0003afff;
	localparam logic [30:0] TPG_SEED_PN23 = 31'h00003aff;
	localparam logic [30:0] TPG_SEED_PN15 = 31'h000003af;
	localparam logic [30:0] TPG_SEED_PN9 = 31'h00000092;
	localparam logic [30:0] TPG_SEED_PN7 = 31'h00000007;

	typedef struct packed {
		logic [30:0] seed;
		logic [4:0] len;
		logic [4:0] tap;
	} tpg_lfsr_cfg_s;

	typedef struct packed {
		logic [30:0] state;
		logic [15:0] word;
	} tpg_step_s;

	typedef struct packed {
		logic [TPG_NUM_SAMPLES-1:0][15:0] word;
	} tpg_frame_s;

endpackage

// >>> rtl/tpg_gen.sv
// Purpose: Link test pattern generator with three injection points
// Assumes: Register port driven by the serial control engine on clk
// Notes:   Sample path is buffered; symbol and octet paths are registered
//
// Operation
// - Low nibble of test control register picks the pattern; zero is off.
// - Bits five and four pick sample, ten-bit symbol or octet injection.
// - Codes three to seven run PN31, PN23, PN15, PN9, PN7 from seeds.
// - Code eight ramps, wrapping at sixteen, ten or eight bits.
// - Code fourteen cycles user patterns one to four endlessly.
// - Code fifteen sends user patterns one to four once, then zeros.
// - Sample point: all four samples of a frame carry one word.
// - Sample point PN9 starts 0x496F, PN23 0xFF5C, toggle 0x0000/0xFFFF.
// - Symbol point advances per symbol; user word bits fifteen to six.
// - Symbol point PN9 starts 0x125, PN23 0x3FD, toggle 0x000/0x3FF.
// - Octet point advances per octet; user word upper bits.
// - Octet point PN9 starts 0x49, PN23 0xFF, toggle 0x00/0xFF.
// - Four sixteen-bit user words sit in eight consecutive byte registers.

// ********************************************************************
// Frame buffer
// ********************************************************************
module tpg_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // tpg_fifo

// ********************************************************************
// Generator top
// ********************************************************************
module tpg_gen
	import tpg_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_write,
	input wire logic cfg_read,
	output logic [7:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire tpg_frame_s sample_in,
	input wire logic sample_in_valid,
	output logic sample_in_ready,
	output tpg_frame_s sample_out,
	output logic sample_out_valid,
	input wire logic sample_out_ready,
	input wire logic [9:0] symbol_in,
	input wire logic symbol_in_valid,
	output logic [9:0] symbol_out,
	output logic symbol_out_valid,
	input wire logic [7:0] octet_in,
	input wire logic octet_in_valid,
	output logic [7:0] octet_out,
	output logic octet_out_valid,
	output logic link_sync_input_disable
);

	// ****************************************************************
	// Serial stepping of the pseudorandom bit stream
	// ****************************************************************
	// The stream is the register read out from bit 0, each new bit being
	// bit 0 xor bit (len - tap); a word takes its first bit as its MSB.
	function automatic tpg_step_s pn_step(input logic [30:0] st_in,
		input logic [4:0] len, input logic [4:0] tap,
		input logic [4:0] w);
		tpg_step_s r;
		logic [30:0] st;
		logic nb;
		st = st_in;
		r.word = '0;
		nb = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (5'(i) < w) begin
				r.word = {r.word[14:0], st[0]};
				nb = st[0] ^ st[len - tap];
				st = st >> 1;
				st[len - 5'h01] = nb;
			end
		end
		r.state = st;
		return r;
	endfunction

	function automatic tpg_lfsr_cfg_s pn_cfg(input logic [3:0] m);
		tpg_lfsr_cfg_s c;
		c = '{seed: TPG_SEED_PN7, len: 5'd7, tap: 5'd6};
		unique case (m)
			TPG_MODE_PN31: c = '{seed: TPG_SEED_PN31, len: 5'd31, tap: 5'd28};
			TPG_MODE_PN23: c = '{seed: TPG_SEED_PN23, len: 5'd23, tap: 5'd18};
			TPG_MODE_PN15: c = '{seed: TPG_SEED_PN15, len: 5'd15, tap: 5'd14};
			TPG_MODE_PN9: c = '{seed: TPG_SEED_PN9, len: 5'd9, tap: 5'd5};
			default: c = '{seed: TPG_SEED_PN7, len: 5'd7, tap: 5'd6};
		endcase
		return c;
	endfunction

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [7:0] test_ctrl;
	logic [7:0] sync_ctrl;
	logic [7:0] user_byte [8];
	logic user_done;

	wire wr_ctrl = cfg_write && (cfg_addr == TPG_ADDR_TEST_CTRL);
	wire wr_sync = cfg_write && (cfg_addr == TPG_ADDR_SYNC_CTRL);
	wire in_user = (cfg_addr >= TPG_ADDR_USER_FIRST) &&
		(cfg_addr <= TPG_ADDR_USER_LAST);
	wire wr_user = cfg_write && in_user;
	wire [15:0] user_off = cfg_addr - TPG_ADDR_USER_FIRST;
	wire [2:0] user_sel = user_off[2:0];
	// Only the full code resets; other values at address zero are ignored
	wire soft_reset = cfg_write && (cfg_addr == TPG_ADDR_SOFT_RESET) &&
		(cfg_wdata == TPG_SOFT_RESET_CODE);
	wire restart = wr_ctrl || soft_reset;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			test_ctrl <= TPG_TEST_CTRL_RESET;
			sync_ctrl <= TPG_SYNC_CTRL_RESET;
		end else if (soft_reset) begin
			test_ctrl <= TPG_TEST_CTRL_RESET;
			sync_ctrl <= TPG_SYNC_CTRL_RESET;
		end else begin
			if (wr_ctrl) begin
				test_ctrl <= cfg_wdata & TPG_TEST_CTRL_WMASK;
			end
			if (wr_sync) begin
				sync_ctrl <= cfg_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				user_byte[i] <= TPG_USER_RESET;
			end
		end else if (soft_reset) begin
			for (int i = 0; i < 8; i++) begin
				user_byte[i] <= TPG_USER_RESET;
			end
		end else if (wr_user) begin
			user_byte[user_sel] <= cfg_wdata;
		end
	end

	assign link_sync_input_disable = (sync_ctrl == TPG_SYNC_DISABLE_CODE);

	// Readback: bit 7 of the test control register shows the single run end
	logic [7:0] next_rdata;
	wire [7:0] ctrl_view = {user_done, test_ctrl[6:0]};
	assign next_rdata = (cfg_addr == TPG_ADDR_TEST_CTRL) ? ctrl_view :
		(cfg_addr == TPG_ADDR_SYNC_CTRL) ? sync_ctrl :
		in_user ? user_byte[user_sel] : 8'h00;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_rdata <= 8'h00;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_read;
			if (cfg_read) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	wire [3:0] mode = test_ctrl[TPG_MODE_LSB +: 4];
	wire [1:0] point = test_ctrl[TPG_POINT_LSB +: 2];
	wire is_pn = (mode >= TPG_MODE_PN31) && (mode <= TPG_MODE_PN7);
	// Undefined codes leave the data untouched rather than guess a pattern
	wire active = (mode != TPG_MODE_OFF) &&
		((mode <= TPG_MODE_RAMP) || (mode == TPG_MODE_USER_REPEAT) ||
		(mode == TPG_MODE_USER_SINGLE));
	wire at_sample = active && (point == TPG_POINT_SAMPLE);
	wire at_phy = active && (point == TPG_POINT_PHY);
	wire at_octet = active && (point == TPG_POINT_SCRAMBLER);
	wire [4:0] word_w = (point == TPG_POINT_PHY) ? TPG_PHY_W :
		(point == TPG_POINT_SCRAMBLER) ? TPG_OCTET_W :
		TPG_SAMPLE_W;
	wire [4:0] drop = TPG_SAMPLE_W - word_w;
	wire [15:0] mask = TPG_TOGGLE_ODD >> drop;

	// ****************************************************************
	// Pattern state
	// ****************************************************************
	logic phase;
	logic [30:0] lfsr;
	logic [15:0] ramp;
	logic [1:0] user_idx;

	wire sample_take = sample_in_valid && sample_in_ready;
	// One advance per frame, symbol or octet at the chosen point
	wire advance = (at_sample && sample_take) || (at_phy && symbol_in_valid) ||
		(at_octet && octet_in_valid);

	tpg_lfsr_cfg_s pcfg;
	tpg_step_s step;
	assign pcfg = pn_cfg(mode);
	assign step = pn_step(lfsr, pcfg.len, pcfg.tap, word_w);

	// Seed of the mode being written, so the first word after the write is set
	tpg_lfsr_cfg_s wcfg;
	assign wcfg = pn_cfg(cfg_wdata[3:0]);

	wire [15:0] user_word = {user_byte[{user_idx, 1'b1}],
		user_byte[{user_idx, 1'b0}]};
	wire [15:0] user_top = user_word >> drop;

	logic [15:0] gen_word;
	assign gen_word =
		(mode == TPG_MODE_CHECKER) ?
			((phase ? TPG_CHECKER_ODD : TPG_CHECKER_EVEN) & mask) :
		(mode == TPG_MODE_TOGGLE) ?
			((phase ? TPG_TOGGLE_ODD : TPG_TOGGLE_EVEN) & mask) :
		is_pn ? step.word :
		(mode == TPG_MODE_RAMP) ? (ramp & mask) :
		(mode == TPG_MODE_USER_REPEAT) ? user_top :
		(mode == TPG_MODE_USER_SINGLE && !user_done) ? user_top :
		16'h0000;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= 1'b0;
			lfsr <= TPG_SEED_PN7;
			ramp <= 16'h0000;
			user_idx <= 2'b00;
			user_done <= 1'b0;
		end else if (restart) begin
			phase <= 1'b0;
			lfsr <= wcfg.seed;
			ramp <= 16'h0000;
			user_idx <= 2'b00;
			user_done <= 1'b0;
		end else if (advance) begin
			phase <= ~phase;
			lfsr <= step.state;
			ramp <= ramp + 16'h0001;
			user_idx <= user_idx + 2'b01;
			if (mode == TPG_MODE_USER_SINGLE && user_idx == 2'b11) begin
				user_done <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Injection into the three data paths
	// ****************************************************************
	// A frame stalled by the buffer does not advance the pattern, so the
	// checker never sees a skipped word under back-pressure.
	tpg_frame_s frame_mux;
	assign frame_mux = at_sample ? {TPG_NUM_SAMPLES{gen_word}} :
		sample_in;

	tpg_fifo #(
		.WIDTH($bits(tpg_frame_s)),
		.DEPTH(TPG_FIFO_DEPTH)
	) i_tpg_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_data(frame_mux),
		.in_valid(sample_in_valid),
		.in_ready(sample_in_ready),
		.out_data(sample_out),
		.out_valid(sample_out_valid),
		.out_ready(sample_out_ready)
	);

	wire [9:0] symbol_mux = at_phy ? gen_word[9:0] : symbol_in;
	wire [7:0] octet_mux = at_octet ? gen_word[7:0] : octet_in;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			symbol_out <= 10'h000;
			symbol_out_valid <= 1'b0;
			octet_out <= 8'h00;
			octet_out_valid <= 1'b0;
		end else begin
			symbol_out_valid <= symbol_in_valid;
			octet_out_valid <= octet_in_valid;
			if (symbol_in_valid) begin
				symbol_out <= symbol_mux;
			end
			if (octet_in_valid) begin
				octet_out <= octet_mux;
			end
		end
	end

endmodule // tpg_gen

// >>> tb/tpg_gen_asserts.sv
// Purpose: Port checks of the link test pattern generator
// Assumes: One clock, reset_n asynchronous and active low
// Notes:   Keeps its own shadow of the test control byte
module tpg_gen_asserts
	import tpg_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_write,
	input wire logic cfg_read,
	input wire logic cfg_rvalid,
	input wire logic [9:0] symbol_in,
	input wire logic symbol_in_valid,
	input wire logic [9:0] symbol_out,
	input wire logic symbol_out_valid,
	input wire logic octet_in_valid,
	input wire logic [7:0] octet_out,
	input wire logic octet_out_valid,
	input wire tpg_frame_s sample_out,
	input wire logic sample_out_valid,
	input wire logic sample_out_ready,
	input wire logic link_sync_input_disable
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Control shadow
	// ****
	logic [7:0] ctrl_q;
	wire soft_rst = cfg_write && cfg_addr == TPG_ADDR_SOFT_RESET
		&& cfg_wdata == TPG_SOFT_RESET_CODE;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= 8'h00;
		end else if (soft_rst) begin
			ctrl_q <= 8'h00;
		end else if (cfg_write && cfg_addr == TPG_ADDR_TEST_CTRL) begin
			ctrl_q <= cfg_wdata & TPG_TEST_CTRL_WMASK;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_read_answer;
		cfg_read |=> cfg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered");
	property p_symbol_beat;
		symbol_in_valid |=> symbol_out_valid;
	endproperty
	a_symbol_beat: assert property (p_symbol_beat)
		else $error("symbol beat lost");
	property p_octet_quiet;
		!octet_in_valid |=> !octet_out_valid;
	endproperty
	a_octet_quiet: assert property (p_octet_quiet)
		else $error("octet without strobe");
	property p_frame_hold;
		sample_out_valid && !sample_out_ready
			|=> sample_out_valid && $stable(sample_out);
	endproperty
	a_frame_hold: assert property (p_frame_hold)
		else $error("frame changed while held");
	property p_octet_checker;
		octet_out_valid && ctrl_q == 8'h21 && $stable(ctrl_q)
			|-> octet_out == 8'h55 || octet_out == 8'haa;
	endproperty
	a_octet_checker: assert property (p_octet_checker)
		else $error("octet checker word wrong");
	property p_sync_disable;
		cfg_write && cfg_addr == TPG_ADDR_SYNC_CTRL |=> link_sync_input_disable
			== ($past(cfg_wdata) == TPG_SYNC_DISABLE_CODE);
	endproperty
	a_sync_disable: assert property (p_sync_disable)
		else $error("sync disable level wrong");
	property p_soft_clear;
		soft_rst |=> !link_sync_input_disable;
	endproperty
	a_soft_clear: assert property (p_soft_clear)
		else $error("soft reset left sync disabled");
	property p_off_pass;
		symbol_in_valid && ctrl_q == 8'h00 && $stable(ctrl_q)
			|=> symbol_out == $past(symbol_in);
	endproperty
	a_off_pass: assert property (p_off_pass)
		else $error("symbol not passed through");
endmodule // tpg_gen_asserts

bind tpg_gen tpg_gen_asserts i_tpg_gen_asserts (.clk(clk), .reset_n(reset_n),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write),
	.cfg_read(cfg_read), .cfg_rvalid(cfg_rvalid), .symbol_in(symbol_in),
	.symbol_in_valid(symbol_in_valid), .symbol_out(symbol_out),
	.symbol_out_valid(symbol_out_valid), .octet_in_valid(octet_in_valid),
	.octet_out(octet_out), .octet_out_valid(octet_out_valid),
	.sample_out(sample_out), .sample_out_valid(sample_out_valid),
	.sample_out_ready(sample_out_ready),
	.link_sync_input_disable(link_sync_input_disable));

// >>> tb/tpg_link_rx.sv
// Purpose: Far-side receiver taking frames from the generator
// Assumes: Ready changes only just after a rising edge
// Notes:   Slow takes every other cycle; stall backs the buffer up
module tpg_link_rx (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic stall,
	input wire logic slow,
	output logic sample_out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sample_out_ready <= 1'b0;
		end else begin
			sample_out_ready <= !stall && (!slow || !sample_out_ready);
		end
	end
endmodule // tpg_link_rx

// >>> tb/tb_tpg_gen.sv
// Purpose: Self-checking bench of the link test pattern generator
// Assumes: Inputs change and outputs are looked at on the falling edge
// Notes:   Drivers queue expected words; the monitor pops one per result
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_tpg_gen
	import tpg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, reset_n = 1'b0, stall = 1'b0, slow = 1'b0;
	logic [15:0] cfg_addr = 16'h0000;
	logic [7:0] cfg_wdata = 8'h00, cfg_rdata, octet_in = 8'h00, octet_out;
	logic cfg_write = 1'b0, cfg_read = 1'b0, cfg_rvalid, sample_in_ready;
	logic sample_in_valid = 1'b0, symbol_in_valid = 1'b0;
	logic octet_in_valid = 1'b0, sample_out_valid, sample_out_ready;
	logic symbol_out_valid, octet_out_valid, link_sync_input_disable;
	logic [9:0] symbol_in = 10'h000, symbol_out;
	tpg_frame_s sample_in = 64'h0, sample_out;
	int n_mismatch = 0, cmp_count = 0, cycles = 0;
	logic [15:0] exp_q[$];
	logic [15:0] up[4];
	// Control byte, then the first three words at its injection point
	logic [55:0] tbl[18] = '{
		56'h01_5555_aaaa_5555, 56'h02_0000_ffff_0000, 56'h06_496f_c9a9_980c,
		56'h04_ff5c_0029_b80a, 56'h08_0000_0001_0002, 56'h11_0155_02aa_0155,
		56'h12_0000_03ff_0000, 56'h16_0125_02fc_026a, 56'h14_03fd_01c0_000a,
		56'h18_0000_0001_0002, 56'h21_0055_00aa_0055, 56'h22_0000_00ff_0000,
		56'h26_0049_006f_00c9, 56'h24_00ff_005c_0000, 56'h28_0000_0001_0002,
		56'h23_00ff_00f5_00c0, 56'h25_00f5_00c0_003c, 56'h27_00e0_0041_0085};
	always #12.5 clk = ~clk;
	tpg_gen i_tpg_gen (.clk(clk), .reset_n(reset_n), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .sample_in(sample_in),
		.sample_in_valid(sample_in_valid), .sample_in_ready(sample_in_ready),
		.sample_out(sample_out), .sample_out_valid(sample_out_valid),
		.sample_out_ready(sample_out_ready), .symbol_in(symbol_in),
		.symbol_in_valid(symbol_in_valid), .symbol_out(symbol_out),
		.symbol_out_valid(symbol_out_valid), .octet_in(octet_in),
		.octet_in_valid(octet_in_valid), .octet_out(octet_out),
		.octet_out_valid(octet_out_valid),
		.link_sync_input_disable(link_sync_input_disable));
	tpg_link_rx i_tpg_link_rx (.clk(clk), .reset_n(reset_n), .stall(stall),
		.slow(slow), .sample_out_ready(sample_out_ready));
	task automatic give_verdict();
		n_mismatch += exp_q.size();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic pop_chk(input string nm, input logic [15:0] g);
		logic [15:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
		`CHK(nm, e, g)
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		cfg_addr = a;
		cfg_wdata = d;
		cfg_write = 1'b1;
		@(negedge clk);
		cfg_write = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back({8'h00, e});
		@(negedge clk);
		cfg_addr = a;
		cfg_read = 1'b1;
		@(negedge clk);
		cfg_read = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// Sends n accepted beats of random data at point p
	task automatic beats(input logic [1:0] p, input int n, input bit pass);
		for (int k = 0; k < n; k++) begin
			@(negedge clk);
			symbol_in = 10'($urandom);
			octet_in = 8'($urandom);
			sample_in = {$urandom, $urandom};
			symbol_in_valid = (p == TPG_POINT_PHY);
			octet_in_valid = (p == TPG_POINT_SCRAMBLER);
			sample_in_valid = (p == TPG_POINT_SAMPLE);
			if (pass) exp_q.push_back({6'h00, symbol_in});
			// A refused frame stays offered, unchanged, until it is taken
			while (sample_in_valid && !sample_in_ready) @(negedge clk);
		end
		@(negedge clk);
		symbol_in_valid = 1'b0;
		octet_in_valid = 1'b0;
		sample_in_valid = 1'b0;
		repeat (12) @(negedge clk);
	endtask
	always @(negedge clk) begin
		if (cfg_rvalid) pop_chk("cfg_rdata", {8'h00, cfg_rdata});
		if (symbol_out_valid) pop_chk("symbol", {6'h00, symbol_out});
		if (octet_out_valid) pop_chk("octet", {8'h00, octet_out});
		if (sample_out_valid && sample_out_ready) begin
			for (int k = 0; k < TPG_NUM_SAMPLES; k++)
				`CHK("sample", exp_q[0], sample_out.word[k])
			if (exp_q.size() > 0) void'(exp_q.pop_front());
		end
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h90b9));
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		rd(TPG_ADDR_TEST_CTRL, TPG_TEST_CTRL_RESET);
		rd(16'h0013, 8'h00);
		wr(TPG_ADDR_TEST_CTRL, 8'hff);
		rd(TPG_ADDR_TEST_CTRL, 8'h3f);
		foreach (tbl[i]) begin
			slow = i[0];
			wr(TPG_ADDR_TEST_CTRL, tbl[i][55:48]);
			for (int j = 2; j >= 0; j--)
				exp_q.push_back(tbl[i][16*j +: 16]);
			beats(tbl[i][53:52], 3, 1'b0);
		end
		wr(TPG_ADDR_TEST_CTRL, 8'h28);
		for (int i = 0; i < 260; i++)
			exp_q.push_back(16'(i % 256));
		beats(TPG_POINT_SCRAMBLER, 260, 1'b0);
		for (int i = 0; i < 4; i++) begin
			up[i] = 16'($urandom);
			wr(TPG_ADDR_USER_FIRST + 16'(2 * i), up[i][7:0]);
			wr(TPG_ADDR_USER_FIRST + 16'(2 * i + 1), up[i][15:8]);
		end
		wr(TPG_ADDR_TEST_CTRL, 8'h1e);
		for (int i = 0; i < 6; i++)
			exp_q.push_back({6'h00, up[i % 4][15:6]});
		beats(TPG_POINT_PHY, 6, 1'b0);
		wr(TPG_ADDR_TEST_CTRL, 8'h0e);
		for (int i = 0; i < 5; i++)
			exp_q.push_back(up[i % 4]);
		beats(TPG_POINT_SAMPLE, 5, 1'b0);
		wr(TPG_ADDR_TEST_CTRL, 8'h2f);
		for (int i = 0; i < 6; i++)
			exp_q.push_back(i < 4 ? {8'h00, up[i][15:8]} : 16'h0);
		beats(TPG_POINT_SCRAMBLER, 6, 1'b0);
		rd(TPG_ADDR_TEST_CTRL, 8'haf);
		// Fill the buffer while stalled; a refused frame must not advance
		wr(TPG_ADDR_TEST_CTRL, 8'h08);
		stall = 1'b1;
		for (int i = 0; i < 5; i++) exp_q.push_back(16'(i));
		beats(TPG_POINT_SAMPLE, 4, 1'b0);
		`CHK("sample_in_ready", 1'b0, sample_in_ready)
		// Offer a fifth frame to the full buffer and hold it until taken
		sample_in_valid = 1'b1;
		repeat (3) @(negedge clk);
		stall = 1'b0;
		while (!sample_in_ready) @(negedge clk);
		@(negedge clk);
		sample_in_valid = 1'b0;
		repeat (12) @(negedge clk);
		// An unused point and an undefined code leave symbols untouched
		for (int i = 0; i < 2; i++) begin
			wr(TPG_ADDR_TEST_CTRL, i ? 8'h19 : 8'h31);
			beats(TPG_POINT_PHY, 2, 1'b1);
		end
		wr(TPG_ADDR_SYNC_CTRL, TPG_SYNC_DISABLE_CODE);
		`CHK("sync_disable", 1'b1, link_sync_input_disable)
		wr(TPG_ADDR_SOFT_RESET, TPG_SOFT_RESET_CODE);
		rd(TPG_ADDR_TEST_CTRL, 8'h00);
		`CHK("sync_disable", 1'b0, link_sync_input_disable)
		beats(TPG_POINT_PHY, 3, 1'b1);
		give_verdict();
	end
endmodule // tb_tpg_gen
